// >>> pkg/pin_port_pkg.sv
// Shared constants and types for the touch converter host port
package pin_port_pkg;

  // ----------------------------------------------------------------
  // Converter channel numbers
  // ----------------------------------------------------------------
  localparam logic [2:0] CH_X_PLUS      = 3'h0;
  localparam logic [2:0] CH_Y_PLUS      = 3'h1;
  localparam logic [2:0] CH_Y_MINUS     = 3'h2;
  localparam logic [2:0] CH_AUX_ONE     = 3'h3;
  localparam logic [2:0] CH_AUX_TWO     = 3'h4;
  localparam logic [2:0] CH_AUX_THREE   = 3'h5;
  localparam logic [2:0] CH_BATTERY_ONE = 3'h6;
  localparam logic [2:0] CH_BATTERY_TWO = 3'h7;

  // ----------------------------------------------------------------
  // Frame layout and reset values
  // ----------------------------------------------------------------
  localparam int         WORD_BITS     = 16;
  localparam logic [4:0] BIT_COUNT_TOP = 5'h10;
  localparam logic [3:0] GPIO_DIR_RST  = 4'h0;
  localparam logic [3:0] GPIO_OUT_RST  = 4'h0;
  // Command word fields: [15] write, [14:12] opcode, [11:0] payload
  localparam int         OP_HI         = 14;
  localparam int         OP_LO         = 12;
  localparam int         SEL_HI        = 2;

  typedef enum logic [2:0]
  {
    OP_READ_RESULT = 3'h0,
    OP_SET_CHANNEL = 3'h1,
    OP_SET_GPIO    = 3'h2,
    OP_SET_AUXMODE = 3'h3,
    OP_SET_LIMITS  = 3'h4
  } opcode_t;

endpackage

// >>> pkg/serial_edge_if.sv
// Synchronised serial pin levels and their edge pulses
interface serial_edge_if;
  logic select_active;
  logic rise;
  logic fall;
  logic data_in;

  modport producer (output select_active, output rise, output fall, output data_in);
  modport consumer (input select_active, input rise, input fall, input data_in);
endinterface

// >>> rtl/serial_sync.sv
// Two-flop synchronisers and edge finder for the host serial pins
module serial_sync
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        select_n_i,
  input  wire logic        serial_clock_in_i,
  input  wire logic        serial_data_i,
  serial_edge_if.producer  edges
);
  logic [1:0] sel_sync_r;
  logic [1:0] clk_sync_r;
  logic [1:0] din_sync_r;
  logic       clk_prev_r;

  // --------------------------------------------------------------
  // Synchronisers; first stages only feed second stages
  // --------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      sel_sync_r <= 2'h3;
      clk_sync_r <= 2'h0;
      din_sync_r <= 2'h0;
      clk_prev_r <= 1'b0;
    end
    else
    begin
      sel_sync_r <= {sel_sync_r[0], select_n_i};
      clk_sync_r <= {clk_sync_r[0], serial_clock_in_i};
      din_sync_r <= {din_sync_r[0], serial_data_i};
      clk_prev_r <= clk_sync_r[1];
    end
  end

  // Edge pulses only count while selected
  assign edges.select_active = ~sel_sync_r[1];
  assign edges.rise          = ~sel_sync_r[1] & clk_sync_r[1] & ~clk_prev_r;
  assign edges.fall          = ~sel_sync_r[1] & ~clk_sync_r[1] & clk_prev_r;
  assign edges.data_in       = din_sync_r[1];
endmodule

// >>> rtl/touch_host_port.sv
// Host-facing serial port and event pins of the touch converter
// How it works
// - Select low starts conversion and enables shifting; high ignores the serial clock
// - Input bits are captured on the serial clock rising edge
// - Output bit changes on each serial clock falling edge
// - Data output is released to high impedance while select is high
// - Result-ready goes low when new results enter the results store
// - Alert goes low on a set general bit (dedicated pin, or aux pin in digital mode) or an out-of-range limit check
// - Pen-touch output is active low, otherwise held high
// - Acquisition halts while the hold input is active
// - Channels: X+ 0, Y+ 1, Y- 2, aux 3 to 5, batteries 6 and 7
// - The three auxiliary pins may be configured as general digital pins
// - One dedicated general digital pin independent of the converter
module touch_host_port
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        select_n_i,
  input  wire logic        serial_clock_in_i,
  input  wire logic        serial_data_i,
  output logic             serial_data_o,
  output logic             serial_data_oe_o,
  input  wire logic        acquisition_hold_in_i,
  input  wire logic        pen_touch_i,
  input  wire logic        result_write_i,
  input  wire logic [11:0] result_value_i,
  input  wire logic [2:0]  result_channel_i,
  input  wire logic        limit_fail_i,
  output logic             convert_start_o,
  output logic             acquire_enable_o,
  output logic [2:0]       channel_select_o,
  output logic             pen_touch_irq_n_o,
  output logic             result_ready_n_o,
  output logic             alert_n_o,
  input  wire logic [3:0]  gpio_pin_i,
  output logic [3:0]       gpio_pin_o,
  output logic [3:0]       gpio_pin_oe_o,
  output logic [2:0]       aux_digital_o
);
  import pin_port_pkg::*;

  serial_edge_if edges ();

  logic [15:0] shift_in_r;
  logic [15:0] shift_out_r;
  logic [4:0]  bit_count_r;
  logic        sel_prev_r;
  logic [11:0] results_r [0:7];
  logic [3:0]  gpio_dir_r;
  logic [3:0]  gpio_out_r;
  logic [2:0]  aux_mode_r;
  logic [2:0]  read_chan_r;
  logic [3:0]  gpio_sync0_r;
  logic [3:0]  gpio_sync1_r;
  logic [1:0]  hold_sync_r;
  logic [1:0]  pen_sync_r;
  logic        limit_flag_r;
  logic        word_done;
  logic [15:0] word_in;
  logic [3:0]  gpio_data;

  // Pin of a general bit is usable when dedicated or aux pin in digital mode
  function automatic logic [3:0] gpio_usable(input logic [2:0] mode);
    gpio_usable = {1'b1, mode};
  endfunction

  serial_sync u_sync
  (
    .clock_i           (clock_i),
    .rst_i             (rst_i),
    .select_n_i        (select_n_i),
    .serial_clock_in_i (serial_clock_in_i),
    .serial_data_i     (serial_data_i),
    .edges             (edges)
  );

  assign word_in   = {shift_in_r[14:0], edges.data_in};
  assign word_done = edges.rise && (bit_count_r == BIT_COUNT_TOP - 5'h1);

  // Data bit of a general pin: written value when output, pin level when input
  assign gpio_data = (gpio_dir_r & gpio_out_r) | (~gpio_dir_r & gpio_sync1_r);

  // --------------------------------------------------------------
  // Serial receive
  // --------------------------------------------------------------
  // Rise pulses are gated by select, so traffic while deselected is lost
  always_ff @(posedge clock_i)
  begin
    if (rst_i || !edges.select_active)
    begin
      shift_in_r  <= 16'h0000;
      bit_count_r <= 5'h00;
    end
    else if (edges.rise)
    begin
      shift_in_r  <= word_in;
      bit_count_r <= word_done ? 5'h00 : bit_count_r + 5'h01;
    end
  end

  // Decode a complete command word; partial words are dropped on deselect
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      gpio_dir_r       <= GPIO_DIR_RST;
      gpio_out_r       <= GPIO_OUT_RST;
      aux_mode_r       <= 3'h0;
      channel_select_o <= CH_X_PLUS;
      read_chan_r      <= CH_X_PLUS;
    end
    else if (word_done && word_in[15])
    begin
      case (opcode_t'(word_in[OP_HI:OP_LO]))
        OP_READ_RESULT: read_chan_r      <= word_in[SEL_HI:0];
        OP_SET_CHANNEL: channel_select_o <= word_in[SEL_HI:0];
        OP_SET_GPIO:
        begin
          gpio_dir_r <= word_in[7:4];
          gpio_out_r <= word_in[3:0];
        end
        OP_SET_AUXMODE: aux_mode_r <= word_in[2:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Serial transmit
  // --------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      sel_prev_r  <= 1'b0;
      shift_out_r <= 16'h0000;
    end
    else
    begin
      sel_prev_r <= edges.select_active;
      if (edges.select_active && !sel_prev_r) // Load selected result at frame start
        shift_out_r <= {1'b0, read_chan_r, results_r[read_chan_r]};
      else if (edges.fall)
        shift_out_r <= {shift_out_r[14:0], 1'b0};
    end
  end

  // Output enable follows select only; the wire floats when deselected
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      serial_data_oe_o <= 1'b0;
      serial_data_o    <= 1'b0;
      convert_start_o  <= 1'b0;
    end
    else
    begin
      serial_data_oe_o <= edges.select_active;
      serial_data_o    <= shift_out_r[15];
      convert_start_o  <= edges.select_active && !sel_prev_r;
    end
  end

  // --------------------------------------------------------------
  // Results store and event pins
  // --------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 8; i++)
        results_r[i] <= 12'h000;
    end
    else if (result_write_i)
      results_r[result_channel_i] <= result_value_i;
  end

  // Ready is cleared by a result read; a new write in that cycle wins
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      result_ready_n_o <= 1'b1;
    else if (result_write_i)
      result_ready_n_o <= 1'b0;
    else if (word_done && word_in[15] && word_in[OP_HI:OP_LO] == OP_READ_RESULT)
      result_ready_n_o <= 1'b1;
  end

  // Limit fault latched until rewritten limits; sticky so a short miss shows
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      limit_flag_r <= 1'b0;
    else if (limit_fail_i)
      limit_flag_r <= 1'b1;
    else if (word_done && word_in[15] && word_in[OP_HI:OP_LO] == OP_SET_LIMITS)
      limit_flag_r <= 1'b0;
  end

  // Pen and hold come from outside this clock, so they are synchronised
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      hold_sync_r       <= 2'h0;
      pen_sync_r        <= 2'h0;
      pen_touch_irq_n_o <= 1'b1;
      acquire_enable_o  <= 1'b1;
      alert_n_o         <= 1'b1;
    end
    else
    begin
      hold_sync_r       <= {hold_sync_r[0], acquisition_hold_in_i};
      pen_sync_r        <= {pen_sync_r[0], pen_touch_i};
      pen_touch_irq_n_o <= ~pen_sync_r[1];
      acquire_enable_o  <= ~hold_sync_r[1];
      alert_n_o         <= ~(limit_flag_r | |(gpio_data & gpio_usable(aux_mode_r)));
    end
  end

  // --------------------------------------------------------------
  // General-purpose pins
  // --------------------------------------------------------------
  // Aux pins in analogue mode never drive, protecting the converter input
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      gpio_pin_o    <= 4'h0;
      gpio_pin_oe_o <= 4'h0;
      aux_digital_o <= 3'h0;
      gpio_sync0_r  <= 4'h0;
      gpio_sync1_r  <= 4'h0;
    end
    else
    begin
      gpio_pin_o    <= gpio_out_r;
      gpio_pin_oe_o <= gpio_dir_r & gpio_usable(aux_mode_r);
      aux_digital_o <= aux_mode_r;
      gpio_sync0_r  <= gpio_pin_i;
      gpio_sync1_r  <= gpio_sync0_r;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  property p_release;
    @(posedge clock_i) disable iff (rst_i)
      !edges.select_active |=> !serial_data_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("output driven while deselected");

  property p_ready;
    @(posedge clock_i) disable iff (rst_i)
      result_write_i |=> !result_ready_n_o;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not asserted after write");

  property p_hold;
    @(posedge clock_i) disable iff (rst_i)
      hold_sync_r[1] |=> !acquire_enable_o;
  endproperty
  a_hold: assert property (p_hold) else $error("acquire while held");

  property p_alert;
    @(posedge clock_i) disable iff (rst_i)
      limit_fail_i |=> ##1 !alert_n_o;
  endproperty
  a_alert: assert property (p_alert) else $error("alert missing");

  property p_shift;
    @(posedge clock_i) disable iff (rst_i)
      (edges.fall && sel_prev_r) |=> shift_out_r == {$past(shift_out_r[14:0]), 1'b0};
  endproperty
  a_shift: assert property (p_shift) else $error("output not shifted on fall");

  property p_idle;
    @(posedge clock_i) disable iff (rst_i)
      !edges.select_active |=> bit_count_r == 5'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("count moved while deselected");

  property p_analog;
    @(posedge clock_i) disable iff (rst_i)
      (aux_mode_r == 3'h0) |=> gpio_pin_oe_o[2:0] == 3'h0;
  endproperty
  a_analog: assert property (p_analog) else $error("analogue aux pin driven");

  property p_pen;
    @(posedge clock_i) disable iff (rst_i)
      pen_sync_r[1] |=> !pen_touch_irq_n_o;
  endproperty
  a_pen: assert property (p_pen) else $error("pen not signalled");

  property p_capture;
    @(posedge clock_i) disable iff (rst_i)
      edges.rise |=> shift_in_r == $past(word_in);
  endproperty
  a_capture: assert property (p_capture) else $error("input bit not captured");

  property p_start;
    @(posedge clock_i) disable iff (rst_i)
      convert_start_o |=> !convert_start_o;
  endproperty
  a_start: assert property (p_start) else $error("start pulse too long");
endmodule

// >>> test/host_master.sv
// Host serial master model that clocks 16-bit frames into the touch port
module host_master
(
  input  wire logic clock_i,
  output logic      select_n_o,
  output logic      serial_clock_o,
  output logic      serial_data_o,
  input  wire logic serial_data_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle: select high and the clock parked low between frames
  initial
  begin
    select_n_o     = 1'b1;
    serial_clock_o = 1'b0;
    serial_data_o  = 1'b0;
  end

  // One frame, MSB first, 32 ns high and low; sel_n high sends it unselected
  task automatic frame(input logic [15:0] word, input logic sel_n, output logic [15:0] rd);
    @(posedge clock_i);
    #1;
    select_n_o = sel_n;
    #32;
    for (int i = 15; i >= 0; i--)
    begin
      serial_data_o = word[i];
      #32 serial_clock_o = 1'b1;
      rd[i] = serial_data_i;
      #32 serial_clock_o = 1'b0;
    end
    #32;
    // Flip the data line so a late capture cannot reuse the last bit
    serial_data_o = ~serial_data_o;
    select_n_o    = 1'b1;
    #40;
  endtask
endmodule

// >>> test/tb.sv
// Self-checking bench for the touch converter host port
module tb
  import pin_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------------
  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic        sel_n, sclk, mosi, miso, sdo, sdo_oe, cstart, acq_en;
  logic        pen_n, rdy_n, alert_n;
  logic        hold = 1'b0, pen = 1'b0, rwr = 1'b0, lfail = 1'b0, miso_last = 1'b0;
  logic [11:0] rval = 12'h000;
  logic [2:0]  rch = 3'h0, chsel, auxd;
  logic [3:0]  gin = 4'h0, gout, goe;
  logic [15:0] rd;
  int          mismatches = 0, checked = 0, starts = 0, oe_cnt = 0;

  always #2.5 clock_i = ~clock_i;

  touch_host_port uut
  (
    .clock_i(clock_i), .rst_i(rst_i), .select_n_i(sel_n), .serial_clock_in_i(sclk),
    .serial_data_i(mosi), .serial_data_o(sdo), .serial_data_oe_o(sdo_oe),
    .acquisition_hold_in_i(hold), .pen_touch_i(pen), .result_write_i(rwr),
    .result_value_i(rval), .result_channel_i(rch), .limit_fail_i(lfail),
    .convert_start_o(cstart), .acquire_enable_o(acq_en), .channel_select_o(chsel),
    .pen_touch_irq_n_o(pen_n), .result_ready_n_o(rdy_n), .alert_n_o(alert_n),
    .gpio_pin_i(gin), .gpio_pin_o(gout), .gpio_pin_oe_o(goe), .aux_digital_o(auxd)
  );

  host_master host
  (
    .clock_i(clock_i), .select_n_o(sel_n), .serial_clock_o(sclk),
    .serial_data_o(mosi), .serial_data_i(miso)
  );

  // Released data line shows the inverse of its last driven bit
  always @(posedge clock_i)
  begin
    if (sdo_oe === 1'b1)
      miso_last <= sdo;
    if (sdo_oe === 1'b1)
      oe_cnt++;
    if (cstart === 1'b1)
      starts++;
  end
  assign miso = (sdo_oe === 1'b1) ? sdo : ~miso_last;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Lands 1 ns past the edge so registered outputs have settled
  task automatic tick(int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic cmd(logic [2:0] op, logic [11:0] pay);
    host.frame({1'b1, op, pay}, 1'b0, rd);
    tick(4);
  endtask

  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    chk("data oe", sdo_oe, 1'b0);
    chk("pen irq", pen_n, 1'b1);
    chk("ready", rdy_n, 1'b1);
    chk("alert", alert_n, 1'b1);
    chk("acq en", acq_en, 1'b1);
    chk("gpio oe", goe, 4'h0);
    chk("aux dig", auxd, 3'h0);
    $display("test reset done");
  endtask

  // Two results back to back, then each is selected and read out
  task automatic t_result();
    int s0;
    int o0;
    @(posedge clock_i);
    rwr <= 1'b1;
    rval <= 12'ha5c;
    rch <= CH_BATTERY_ONE;
    @(posedge clock_i);
    rval <= 12'h3c1;
    rch <= CH_AUX_ONE;
    @(posedge clock_i);
    rwr <= 1'b0;
    tick(1);
    chk("ready set", rdy_n, 1'b0);
    s0 = starts;
    o0 = oe_cnt;
    cmd(OP_READ_RESULT, {9'h000, CH_BATTERY_ONE});
    chk("start pulse", 16'(starts - s0), 16'h0001);
    chk("oe in frame", 16'(oe_cnt > o0), 16'h0001);
    chk("oe after", sdo_oe, 1'b0);
    chk("ready clr", rdy_n, 1'b1);
    host.frame(16'h0000, 1'b0, rd);
    tick(4);
    chk("read bat", rd, {1'b0, CH_BATTERY_ONE, 12'ha5c});
    cmd(OP_READ_RESULT, {9'h000, CH_AUX_ONE});
    host.frame(16'h0000, 1'b0, rd);
    tick(4);
    chk("read aux", rd, {1'b0, CH_AUX_ONE, 12'h3c1});
    $display("test result done");
  endtask

  // A full word clocked while unselected must change nothing
  task automatic t_ignored();
    int s0;
    int o0;
    s0 = starts;
    o0 = oe_cnt;
    host.frame({1'b1, OP_SET_GPIO, 12'h0ff}, 1'b1, rd);
    tick(4);
    chk("ign gpio", goe, 4'h0);
    chk("ign start", 16'(starts - s0), 16'h0000);
    chk("ign oe", 16'(oe_cnt - o0), 16'h0000);
    $display("test ignored done");
  endtask

  // Aux bits drive and alert only once their pins are switched to digital
  task automatic t_gpio();
    cmd(OP_SET_GPIO, 12'h0f5);
    chk("gpio oe", goe, 4'h8);
    chk("gpio out", gout, 4'h5);
    chk("gpio alert", alert_n, 1'b1);
    cmd(OP_SET_AUXMODE, 12'h007);
    chk("aux dig", auxd, 3'h7);
    chk("aux oe", goe, 4'hf);
    chk("aux alert", alert_n, 1'b0);
    cmd(OP_SET_GPIO, 12'h0f0);
    chk("alert off", alert_n, 1'b1);
    cmd(OP_SET_AUXMODE, 12'h000);
    chk("aux ana", auxd, 3'h0);
    chk("ana oe", goe, 4'h8);
    cmd(OP_SET_GPIO, 12'h000);
    @(posedge clock_i);
    gin <= 4'h8;
    tick(4);
    chk("pin alert", alert_n, 1'b0);
    @(posedge clock_i);
    gin <= 4'h0;
    tick(4);
    chk("pin idle", alert_n, 1'b1);
    $display("test gpio done");
  endtask

  // Limit flag is sticky until the set-limits command
  task automatic t_limit();
    @(posedge clock_i);
    lfail <= 1'b1;
    @(posedge clock_i);
    lfail <= 1'b0;
    tick(2);
    chk("limit alert", alert_n, 1'b0);
    tick(10);
    chk("limit hold", alert_n, 1'b0);
    cmd(OP_SET_LIMITS, 12'h000);
    chk("limit clr", alert_n, 1'b1);
    $display("test limit done");
  endtask

  task automatic t_chan();
    for (int i = 0; i < 8; i++)
    begin
      cmd(OP_SET_CHANNEL, {9'h000, i[2:0]});
      chk("channel", chsel, i[2:0]);
    end
    $display("test channel done");
  endtask

  task automatic t_pins();
    @(posedge clock_i);
    hold <= 1'b1;
    pen <= 1'b1;
    tick(6);
    chk("acq held", acq_en, 1'b0);
    chk("pen low", pen_n, 1'b0);
    @(posedge clock_i);
    hold <= 1'b0;
    pen <= 1'b0;
    tick(6);
    chk("acq run", acq_en, 1'b1);
    chk("pen high", pen_n, 1'b1);
    $display("test pins done");
  endtask

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    tick(3);
    t_reset();
    t_result();
    t_ignored();
    t_gpio();
    t_limit();
    t_chan();
    t_pins();
    complete_run();
  end

  // About 20 frames are expected; allow several times that
  initial
  begin
    #100us;
    mismatches++;
    complete_run();
  end
endmodule
